// ==== include/annun_pkg.sv ====
// shared constants and types for the alarm first-out and event log block
package annun_pkg;
	// channel count and event log shape
	localparam int NCH = 16;
	localparam int EV_DEPTH = 9;
	localparam int EV_W = 6;
	// clock rate and documented times
	localparam longint CLK_CYC_PER_MS = 200000;
	localparam longint TEST_HOLD_MS = 1000;
	localparam longint FAULT_HOLD_MS = 15000;
	localparam longint PROG_HOLD_MS = 1000;
	localparam longint BLINK_HALF_MS = 500;
	localparam longint TEST_HOLD_CYC = TEST_HOLD_MS * CLK_CYC_PER_MS;
	localparam longint FAULT_HOLD_CYC = FAULT_HOLD_MS * CLK_CYC_PER_MS;
	localparam longint PROG_HOLD_CYC = PROG_HOLD_MS * CLK_CYC_PER_MS;
	localparam longint BLINK_HALF_CYC = BLINK_HALF_MS * CLK_CYC_PER_MS;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_SEQPROG = 8'h08;
	localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
	localparam logic [7:0] REG_IRQ_CLR = 8'h10;
	localparam logic [7:0] REG_IRQ_EN = 8'h14;
	localparam logic [7:0] REG_SLOG_IDX = 8'h18;
	localparam logic [7:0] REG_SLOG_DATA = 8'h1c;
	// control register bit positions
	localparam int CTRL_SIL = 0;
	localparam int CTRL_ACK = 1;
	localparam int CTRL_RST = 2;
	// interrupt bit positions
	localparam int IRQ_FIRST = 0;
	localparam int IRQ_EVENT = 1;
	localparam int IRQ_FAULT = 2;
	localparam int IRQ_REFUSE = 3;
	// relay slots
	localparam int RLY_REFLASH1 = 0;
	localparam int RLY_REFLASH2 = 1;
	localparam int RLY_SUPER = 2;
	localparam int RLY_AUDIBLE = 3;
	// display codes
	localparam logic [3:0] DIG_A = 4'ha;
	localparam logic [3:0] DIG_PROG = 4'hc;
	localparam logic [15:0] DIG_TEST = 16'h8888;
	// bus answers
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {seq_idle, seq_silence, seq_ack, seq_reset} seq_e;
endpackage

// ==== verilog/press_timer.sv ====
// push-button press edge and hold-time detector
`timescale 1ns/100ps
`default_nettype none
module press_timer #(
	parameter logic [31:0] HOLD1_CYC = 32'h0000_0001,
	parameter logic [31:0] HOLD2_CYC = 32'h0000_0001
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic button,
	output logic press,
	output logic hold1,
	output logic hold2
);
	typedef struct packed {
		logic prev;
		logic [31:0] cnt;
	} timer_s;
	timer_s st_q, st_d;

	// count held cycles, saturating at the longer hold
	always_comb begin
		st_d = st_q;
		st_d.prev = button;
		if (!button) begin
			st_d.cnt = 32'h0;
		end else if (st_q.cnt < HOLD2_CYC) begin
			st_d.cnt = st_q.cnt + 32'h1;
		end
		if (!aresetn) begin
			st_d = '0;
		end
	end

	always_ff @(posedge aclk) begin
		st_q <= st_d;
	end

	// press is one cycle on the rising level
	assign press = button & ~st_q.prev;
	assign hold1 = button && (st_q.cnt >= HOLD1_CYC);
	assign hold2 = button && (st_q.cnt >= HOLD2_CYC);
endmodule
`default_nettype wire

// ==== verilog/event_log.sv ====
// nine-deep newest-first event store
`timescale 1ns/100ps
`default_nettype none
module event_log (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic push,
	input wire logic [annun_pkg::EV_W-1:0] push_data,
	input wire logic clear,
	input wire logic [3:0] rd_idx,
	output logic [annun_pkg::EV_W-1:0] rd_data,
	output logic [3:0] count
);
	typedef struct packed {
		logic [annun_pkg::EV_DEPTH-1:0][annun_pkg::EV_W-1:0] ent;
		logic [3:0] count;
	} log_s;
	log_s st_q, st_d;

	// clear first, then a push on the same cycle still lands
	always_comb begin
		st_d = st_q;
		if (clear) begin
			st_d = '0;
		end
		if (push) begin
			for (int i = annun_pkg::EV_DEPTH - 1; i > 0; i--) begin
				st_d.ent[i] = st_d.ent[i-1];
			end
			st_d.ent[0] = push_data;
			if (st_d.count < 4'(annun_pkg::EV_DEPTH)) begin
				st_d.count = st_d.count + 4'h1;
			end
		end
		if (!aresetn) begin
			st_d = '0;
		end
	end

	always_ff @(posedge aclk) begin
		st_q <= st_d;
	end

	// index 0 is the newest entry
	assign rd_data = (rd_idx < st_q.count) ? st_q.ent[rd_idx] : '0;
	assign count = st_q.count;
endmodule
`default_nettype wire

// ==== verilog/alarm_first_out_event_log.sv ====
// annunciator front panel: first-out, silence/ack/reset sequence, event log, bus
`timescale 1ns/100ps
`default_nettype none
module alarm_first_out_event_log #(
	parameter logic [31:0] TEST_HOLD_CYC = 32'(annun_pkg::TEST_HOLD_CYC),
	parameter logic [31:0] FAULT_HOLD_CYC = 32'(annun_pkg::FAULT_HOLD_CYC),
	parameter logic [31:0] PROG_HOLD_CYC = 32'(annun_pkg::PROG_HOLD_CYC),
	parameter logic [31:0] BLINK_HALF_CYC = 32'(annun_pkg::BLINK_HALF_CYC)
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [15:0] alarm_in,
	input wire logic reset_button,
	input wire logic readout_button,
	input wire logic channel_select_button,
	input wire logic value_select_button,
	input wire logic audible_silence_input,
	input wire logic ext_reset_input,
	input wire logic programming_blocked_position,
	input wire logic reflash_one_mode_jumper,
	input wire logic reflash_two_mode_jumper,
	input wire logic supervision_relay_mode_jumper,
	input wire logic audible_relay_mode_jumper,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic [15:0] display_digits,
	output logic display_blank,
	output logic [15:0] channel_leds,
	output logic on_led,
	output logic fault_led,
	output logic silence_led,
	output logic ack_led,
	output logic reset_led,
	output logic prog_led,
	output logic reflash_one_contact,
	output logic reflash_two_contact,
	output logic supervision_contact,
	output logic audible_contact,
	output logic irq
);
	typedef struct packed {
		logic [15:0] alarm_prev;
		logic [15:0] latched;
		logic [15:0] unack;
		logic [15:0] pend;
		logic [15:0] flash_en;
		annun_pkg::seq_e seq;
		logic audible;
		logic first_armed;
		logic first_valid;
		logic [4:0] first_ch;
		logic [3:0] rd_pos;
		logic prog;
		logic op_hold_prev;
		logic [3:0] cursor;
		logic staged;
		logic fault;
		logic [1:0] ext_prev;
		logic [31:0] blink_cnt;
		logic blink;
		logic [3:0] irq_stat;
		logic [3:0] irq_en;
		logic [3:0] slog_idx;
		logic irq;
		logic [15:0] disp;
		logic disp_blank;
		logic [15:0] chan_led;
		logic [5:0] leds;
		logic [3:0] relay;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} top_s;
	top_s st_q, st_d;

	// lowest pending channel as number 1..16, zero when none
	function automatic logic [4:0] first_set(input logic [15:0] v);
		logic [4:0] r;
		r = 5'h0;
		for (int i = 15; i >= 0; i--) begin
			if (v[i]) begin
				r = 5'(i + 1);
			end
		end
		return r;
	endfunction

	// channel number to two decimal digits
	function automatic logic [7:0] to_bcd(input logic [4:0] n);
		logic [7:0] r;
		r = (n >= 5'd10) ? {4'h1, 4'(n - 5'd10)} : {4'h0, n[3:0]};
		return r;
	endfunction

	// byte-lane merge for a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
		input logic [1:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = nw[7:0];
		end
		if (strb[1]) begin
			r[15:8] = nw[15:8];
		end
		return r;
	endfunction

	logic rp_press, rp_hold1, rp_hold2, op_press, op_hold1, cp_press, vp_press;
	logic [15:0] rising;
	logic [4:0] log_ch;
	logic test_cond, prog_req, front, wr_fire, loc_clear;
	logic [5:0] loc_rd_data, ser_rd_data;
	logic [3:0] loc_count, ser_count, loc_rd_idx;

	press_timer #(.HOLD1_CYC(TEST_HOLD_CYC), .HOLD2_CYC(FAULT_HOLD_CYC)) u_reset_btn (
		.aclk(aclk), .aresetn(aresetn), .button(reset_button),
		.press(rp_press), .hold1(rp_hold1), .hold2(rp_hold2));
	press_timer #(.HOLD1_CYC(PROG_HOLD_CYC), .HOLD2_CYC(PROG_HOLD_CYC)) u_readout_btn (
		.aclk(aclk), .aresetn(aresetn), .button(readout_button),
		.press(op_press), .hold1(op_hold1), .hold2());
	press_timer u_chan_btn (
		.aclk(aclk), .aresetn(aresetn), .button(channel_select_button),
		.press(cp_press), .hold1(), .hold2());
	press_timer u_value_btn (
		.aclk(aclk), .aresetn(aresetn), .button(value_select_button),
		.press(vp_press), .hold1(), .hold2());

	// shared decode terms
	assign rising = alarm_in & ~st_q.alarm_prev;
	assign log_ch = first_set(st_q.pend);
	assign test_cond = rp_hold1 && (st_q.seq == annun_pkg::seq_idle) && (st_q.latched == 16'h0)
		&& !st_q.prog;
	assign prog_req = op_hold1 && !st_q.op_hold_prev && !st_q.prog;
	assign front = rp_press && !st_q.prog;
	assign wr_fire = st_q.aw_got && st_q.w_got && !st_q.bvalid;
	assign loc_clear = prog_req && !programming_blocked_position;
	assign loc_rd_idx = st_q.rd_pos - 4'h1;

	event_log u_local_log (
		.aclk(aclk), .aresetn(aresetn), .push(log_ch != 5'h0), .push_data({1'b1, log_ch}),
		.clear(loc_clear), .rd_idx(loc_rd_idx), .rd_data(loc_rd_data), .count(loc_count));
	// serial log, cleared by power loss only
	event_log u_serial_log (
		.aclk(aclk), .aresetn(aresetn), .push(log_ch != 5'h0), .push_data({1'b1, log_ch}),
		.clear(1'b0), .rd_idx(st_q.slog_idx), .rd_data(ser_rd_data), .count(ser_count));

	// next state of the whole block
	always_comb begin
		logic ctrl_sil, ctrl_ack, ctrl_rst, do_sil, do_ack, do_rst;
		logic [3:0] irq_set, irq_clr;
		logic [7:0] bcd;
		ctrl_sil = 1'b0;
		ctrl_ack = 1'b0;
		ctrl_rst = 1'b0;
		irq_set = 4'h0;
		irq_clr = 4'h0;
		bcd = 8'h0;
		do_sil = 1'b0;
		do_ack = 1'b0;
		do_rst = 1'b0;
		st_d = st_q;
		// bus write: address and data in either order
		if (awvalid && st_q.awready) begin
			st_d.aw_got = 1'b1;
			st_d.aw_addr = awaddr;
		end
		if (wvalid && st_q.wready) begin
			st_d.w_got = 1'b1;
			st_d.w_data = wdata;
			st_d.w_strb = wstrb;
		end
		if (bready && st_q.bvalid) begin
			st_d.bvalid = 1'b0;
		end
		if (wr_fire) begin
			st_d.aw_got = 1'b0;
			st_d.w_got = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = annun_pkg::RESP_OK;
			unique case (st_q.aw_addr)
				annun_pkg::REG_CTRL: begin
					ctrl_sil = st_q.w_strb[0] && st_q.w_data[annun_pkg::CTRL_SIL];
					ctrl_ack = st_q.w_strb[0] && st_q.w_data[annun_pkg::CTRL_ACK];
					ctrl_rst = st_q.w_strb[0] && st_q.w_data[annun_pkg::CTRL_RST];
				end
				annun_pkg::REG_SEQPROG: st_d.flash_en = merge16(st_q.flash_en,
					st_q.w_data[15:0], st_q.w_strb[1:0]);
				annun_pkg::REG_IRQ_CLR: irq_clr = st_q.w_strb[0] ? st_q.w_data[3:0] : 4'h0;
				annun_pkg::REG_IRQ_EN: st_d.irq_en = st_q.w_strb[0] ? st_q.w_data[3:0] : st_q.irq_en;
				annun_pkg::REG_SLOG_IDX: st_d.slog_idx = st_q.w_strb[0] ? st_q.w_data[3:0] : st_q.slog_idx;
				annun_pkg::REG_STATUS, annun_pkg::REG_IRQ_STAT, annun_pkg::REG_SLOG_DATA: begin
				end
				default: st_d.bresp = annun_pkg::RESP_SLVERR;
			endcase
		end
		// bus read, one cycle to rvalid
		if (rready && st_q.rvalid) begin
			st_d.rvalid = 1'b0;
		end
		if (arvalid && st_q.arready) begin
			st_d.rvalid = 1'b1;
			st_d.rresp = annun_pkg::RESP_OK;
			st_d.rdata = 32'h0;
			unique case (araddr)
				annun_pkg::REG_CTRL, annun_pkg::REG_IRQ_CLR: begin
				end
				annun_pkg::REG_STATUS: st_d.rdata = {21'h0, st_q.fault, st_q.audible,
					2'(st_q.seq), st_q.prog, st_q.first_valid, st_q.first_ch};
				annun_pkg::REG_SEQPROG: st_d.rdata = {16'h0, st_q.flash_en};
				annun_pkg::REG_IRQ_STAT: st_d.rdata = {28'h0, st_q.irq_stat};
				annun_pkg::REG_IRQ_EN: st_d.rdata = {28'h0, st_q.irq_en};
				annun_pkg::REG_SLOG_IDX: st_d.rdata = {28'h0, st_q.slog_idx};
				annun_pkg::REG_SLOG_DATA: st_d.rdata = {22'h0, ser_count, ser_rd_data};
				default: st_d.rresp = annun_pkg::RESP_SLVERR;
			endcase
		end
		st_d.awready = !st_d.aw_got && !st_d.bvalid;
		st_d.wready = !st_d.w_got && !st_d.bvalid;
		st_d.arready = !st_d.rvalid;

		// external inputs act on their rising level
		st_d.ext_prev = {ext_reset_input, audible_silence_input};
		do_sil = (front && st_q.seq == annun_pkg::seq_silence) || ctrl_sil
			|| (audible_silence_input && !st_q.ext_prev[0]);
		do_ack = (front && st_q.seq == annun_pkg::seq_ack) || ctrl_ack
			|| (ext_reset_input && !st_q.ext_prev[1]);
		do_rst = (front && st_q.seq == annun_pkg::seq_reset) || ctrl_rst;
		// do the shown function and advance
		if (do_sil) begin
			st_d.audible = 1'b0;
			if (st_q.seq == annun_pkg::seq_silence) begin
				st_d.seq = annun_pkg::seq_ack;
			end
		end
		if (do_ack) begin
			st_d.audible = 1'b0;
			st_d.unack = 16'h0;
			if (st_q.seq == annun_pkg::seq_silence || st_q.seq == annun_pkg::seq_ack) begin
				st_d.seq = annun_pkg::seq_reset;
			end
		end
		if (do_rst) begin
			st_d.latched = st_q.latched & alarm_in;
			if (st_d.latched == 16'h0) begin
				st_d.seq = annun_pkg::seq_idle;
			end
		end
		// new alarms start their channels; set wins over clears
		st_d.alarm_prev = alarm_in;
		if (rising != 16'h0) begin
			st_d.latched = st_d.latched | rising;
			st_d.unack = st_d.unack | rising;
			st_d.audible = 1'b1;
			st_d.seq = annun_pkg::seq_silence;
		end
		// starts queue up, one logged per cycle
		st_d.pend = (st_q.pend & ~(16'h1 << (log_ch - 5'h1))) | rising;
		if (log_ch != 5'h0) begin
			irq_set[annun_pkg::IRQ_EVENT] = 1'b1;
		end
		// front button clears first-out and rearms
		if (front) begin
			st_d.first_valid = 1'b0;
			st_d.first_armed = 1'b1;
		end
		// first start after rearm is latched
		if (st_q.first_armed && log_ch != 5'h0) begin
			st_d.first_valid = 1'b1;
			st_d.first_armed = 1'b0;
			st_d.first_ch = log_ch;
			irq_set[annun_pkg::IRQ_FIRST] = 1'b1;
		end
		// step newest to oldest, then blank
		if (op_press && !st_q.prog) begin
			if (st_q.rd_pos == 4'h0) begin
				st_d.rd_pos = (loc_count != 4'h0) ? 4'h1 : 4'h0;
			end else if (st_q.rd_pos < loc_count) begin
				st_d.rd_pos = st_q.rd_pos + 4'h1;
			end else begin
				st_d.rd_pos = 4'h0;
			end
		end
		// local programming with the panel buttons
		if (st_q.prog) begin
			if (op_press) begin
				st_d.prog = 1'b0;
			end
			if (cp_press) begin
				st_d.cursor = st_q.cursor + 4'h1;
				st_d.staged = st_q.flash_en[st_q.cursor + 4'h1];
			end
			if (vp_press) begin
				st_d.staged = ~st_q.staged;
			end
			if (rp_press) begin
				st_d.flash_en[st_q.cursor] = st_q.staged;
			end
		end
		st_d.op_hold_prev = op_hold1;
		if (prog_req) begin
			if (programming_blocked_position) begin
				irq_set[annun_pkg::IRQ_REFUSE] = 1'b1;
			end else begin
				st_d.prog = 1'b1;
				st_d.rd_pos = 4'h0;
				st_d.cursor = 4'h0;
				st_d.staged = st_q.flash_en[0];
			end
		end
		// long hold drops supervision, lights fault
		st_d.fault = test_cond && rp_hold2;
		if (st_d.fault && !st_q.fault) begin
			irq_set[annun_pkg::IRQ_FAULT] = 1'b1;
		end
		// flash timebase
		st_d.blink_cnt = st_q.blink_cnt + 32'h1;
		if (st_q.blink_cnt >= BLINK_HALF_CYC - 32'h1) begin
			st_d.blink_cnt = 32'h0;
			st_d.blink = ~st_q.blink;
		end
		// sticky status, set wins over clear
		st_d.irq_stat = (st_q.irq_stat & ~irq_clr) | irq_set;
		st_d.irq = |(st_d.irq_stat & st_d.irq_en);

		st_d.chan_led = test_cond ? 16'hffff
			: (st_q.latched & ~(st_q.unack & st_q.flash_en & {16{~st_q.blink}}));
		st_d.leds = {1'b1, st_q.fault, test_cond || st_q.seq == annun_pkg::seq_silence,
			test_cond || st_q.seq == annun_pkg::seq_ack,
			test_cond || st_q.seq == annun_pkg::seq_reset, test_cond || st_q.prog};
		// display priority: test, programming, readout, first-out
		st_d.disp_blank = 1'b0;
		if (test_cond) begin
			st_d.disp = annun_pkg::DIG_TEST;
		end else if (st_q.prog) begin
			bcd = to_bcd(5'(st_q.cursor) + 5'h1);
			st_d.disp = {annun_pkg::DIG_PROG, bcd, 3'h0, st_q.staged};
		end else if (st_q.rd_pos != 4'h0) begin
			bcd = to_bcd(loc_rd_data[4:0]);
			st_d.disp = {st_q.rd_pos, 3'h0, loc_rd_data[5], bcd};
		end else if (st_q.first_valid) begin
			bcd = to_bcd(st_q.first_ch);
			st_d.disp = {annun_pkg::DIG_A, 4'h0, bcd};
		end else begin
			st_d.disp = 16'h0;
			st_d.disp_blank = 1'b1;
		end
		// energised state turned into contact by jumper
		st_d.relay[annun_pkg::RLY_REFLASH1] = (|st_q.unack[7:0]) ^ reflash_one_mode_jumper;
		st_d.relay[annun_pkg::RLY_REFLASH2] = (|st_q.unack[15:8]) ^ reflash_two_mode_jumper;
		st_d.relay[annun_pkg::RLY_SUPER] = ~st_q.fault ^ supervision_relay_mode_jumper;
		st_d.relay[annun_pkg::RLY_AUDIBLE] = st_q.audible ^ audible_relay_mode_jumper;
		// parameters survive reset like a non-volatile store
		if (!aresetn) begin
			st_d = '0;
			st_d.flash_en = st_q.flash_en;
			st_d.first_armed = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		st_q <= st_d;
	end

	// outputs straight from state
	assign {on_led, fault_led, silence_led, ack_led, reset_led, prog_led} = st_q.leds;
	assign display_digits = st_q.disp;
	assign display_blank = st_q.disp_blank;
	assign channel_leds = st_q.chan_led;
	assign reflash_one_contact = st_q.relay[annun_pkg::RLY_REFLASH1];
	assign reflash_two_contact = st_q.relay[annun_pkg::RLY_REFLASH2];
	assign supervision_contact = st_q.relay[annun_pkg::RLY_SUPER];
	assign audible_contact = st_q.relay[annun_pkg::RLY_AUDIBLE];
	assign irq = st_q.irq;
	assign awready = st_q.awready;
	assign wready = st_q.wready;
	assign bvalid = st_q.bvalid;
	assign bresp = st_q.bresp;
	assign arready = st_q.arready;
	assign rvalid = st_q.rvalid;
	assign rdata = st_q.rdata;
	assign rresp = st_q.rresp;

	// checks on the panel behaviour
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	first_out_a: assert property ((st_q.first_armed && log_ch != 5'h0) |=>
		(st_q.first_valid && st_q.first_ch == $past(log_ch))) else $error("first-out not latched");
	fo_clear_a: assert property (front |=> !st_q.first_valid)
		else $error("first-out not cleared");
	log_depth_a: assert property (loc_count <= 4'h9 && ser_count <= 4'h9)
		else $error("event log over depth");
	read_wrap_a: assert property ((op_press && !st_q.prog && st_q.rd_pos != 4'h0
		&& st_q.rd_pos >= loc_count) |=> st_q.rd_pos == 4'h0) else $error("readout not blanked");
	read_restart_a: assert property ((op_press && !st_q.prog && st_q.rd_pos == 4'h0
		&& loc_count != 4'h0) |=> st_q.rd_pos == 4'h1) else $error("readout not at newest");
	prog_erase_a: assert property (loc_clear |=> (st_q.prog && loc_count <= 4'h1))
		else $error("local log not erased");
	serial_keep_a: assert property (loc_clear |=> ser_count >= $past(ser_count))
		else $error("serial log lost");
	idle_quiet_a: assert property ((st_q.seq == annun_pkg::seq_idle && st_q.latched == 16'h0
		&& !test_cond && !st_q.prog && !st_q.fault) |=> (on_led && channel_leds == 16'h0
		&& !silence_led && !ack_led && !reset_led && !prog_led && !fault_led))
		else $error("lamp lit in quiet state");
	chan_start_a: assert property ((rising != 16'h0) |=>
		((st_q.latched & $past(rising)) == $past(rising) && st_q.seq == annun_pkg::seq_silence))
		else $error("channel not started");
	next_lamp_a: assert property ((st_q.seq == annun_pkg::seq_ack && !test_cond) |=>
		(ack_led && !silence_led && !reset_led)) else $error("wrong sequence lamp");
	reset_func_a: assert property ((front && st_q.seq == annun_pkg::seq_reset
		&& rising == 16'h0) |=> (st_q.latched & ~$past(alarm_in)) == 16'h0)
		else $error("channel not returned");
	ext_ack_a: assert property ((ext_reset_input && !st_q.ext_prev[1]
		&& rising == 16'h0) |=> (st_q.unack == 16'h0 && !st_q.audible))
		else $error("external acknowledge ignored");
	prog_block_a: assert property ((prog_req && programming_blocked_position)
		|=> !st_q.prog ##1 !st_q.prog) else $error("blocked entry taken");
	contact_a: assert property (audible_contact == ($past(st_q.audible)
		^ $past(audible_relay_mode_jumper))) else $error("audible contact mode wrong");
	lamp_test_a: assert property (test_cond |=> display_digits == 16'h8888)
		else $error("lamp test pattern missing");
	seq_adv_a: assert property ((front && st_q.seq == annun_pkg::seq_silence
		&& rising == 16'h0) |=> (st_q.seq == annun_pkg::seq_ack && !st_q.audible))
		else $error("sequence not advanced");
	first_c: cover property (st_q.first_armed && log_ch != 5'h0);
	wrap_c: cover property (op_press && st_q.rd_pos == 4'h9);
	fault_c: cover property (st_d.fault && !st_q.fault);
endmodule
`default_nettype wire

// ==== sim/panel_model.sv ====
// operator panel model: holds a requested button for a set count
`timescale 1ns/100ps
`default_nettype none
module panel_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [5:0] req,
	input wire logic [7:0] hold,
	output logic [5:0] btn
);
	logic [7:0] cnt_q;
	// external buttons press like front ones
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			btn <= 6'h00;
			cnt_q <= 8'h00;
		end else if (|req) begin
			btn <= req;
			cnt_q <= hold;
		end else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
		else btn <= 6'h00;
	end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench for the annunciator front panel block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n,e,a) begin samples_checked++; if ((a)!==(e)) begin mismatches++; \
$display("Error %s exp %h got %h",n,e,a); end end
module tb_top;
	logic aclk=0, aresetn=0, awvalid=0, wvalid=0, bready=0, arvalid=0, rready=0, blk=0;
	logic [15:0] alarm=16'h0000;
	logic [3:0] jmp=4'h0;
	logic [7:0] awaddr=8'h00, araddr=8'h00, hold=8'h00;
	logic [31:0] wdata=32'h0, rd, rdata;
	logic [5:0] req=6'h00, btn;
	logic [1:0] rp, rresp, bp, br;
	logic awready, wready, bvalid, arready, rvalid, blank, on, flt, sil, ack, rst, irq, pl;
	logic [15:0] dig, leds;
	logic [3:0] ct;
	int mismatches=0, samples_checked=0, cyc=0;
	always #2.5 aclk = ~aclk;
	panel_model panel_model_i (.aclk(aclk), .aresetn(aresetn), .req(req), .hold(hold), .btn(btn));
	alarm_first_out_event_log #(.TEST_HOLD_CYC(32'h14), .FAULT_HOLD_CYC(32'h3c),
		.PROG_HOLD_CYC(32'h14), .BLINK_HALF_CYC(32'h4)) alarm_first_out_event_log_i (
		.aclk(aclk), .aresetn(aresetn), .alarm_in(alarm), .reset_button(btn[0]),
		.readout_button(btn[1]), .channel_select_button(btn[2]), .value_select_button(btn[3]),
		.audible_silence_input(btn[4]), .ext_reset_input(btn[5]),
		.programming_blocked_position(blk), .reflash_one_mode_jumper(jmp[3]),
		.reflash_two_mode_jumper(jmp[2]), .supervision_relay_mode_jumper(jmp[1]),
		.audible_relay_mode_jumper(jmp[0]), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
		.bresp(br), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.display_digits(dig), .display_blank(blank), .channel_leds(leds), .on_led(on),
		.fault_led(flt), .silence_led(sil), .ack_led(ack), .reset_led(rst), .prog_led(pl),
		.reflash_one_contact(ct[3]), .reflash_two_contact(ct[2]),
		.supervision_contact(ct[1]), .audible_contact(ct[0]), .irq(irq));
	task automatic clk(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw;
		ta = 0;
		tw = 0;
		awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
		while (!(ta && tw)) begin
			@(posedge aclk);
			if (awready && !ta) begin ta = 1; awvalid <= 0; end
			if (wready && !tw) begin tw = 1; wvalid <= 0; end
		end
		do @(posedge aclk); while (!bvalid);
		bp = br;
		bready <= 0;
		@(posedge aclk);
	endtask
	task automatic rdr(input logic [7:0] a);
		araddr <= a; arvalid <= 1; rready <= 1;
		do @(posedge aclk); while (!arready);
		arvalid <= 0;
		do @(posedge aclk); while (!rvalid);
		rd = rdata; rp = rresp; rready <= 0;
		@(posedge aclk);
	endtask
	task automatic pr(input logic [5:0] b, input logic [7:0] h);
		req <= b; hold <= h;
		@(posedge aclk);
		req <= 6'h00;
		clk(h + 6);
	endtask
	task automatic t_alarm;
		alarm <= 16'h0008; clk(6);
		`CHK("first", 16'ha004, dig)
		`CHK("chan", 16'h0008, leds)
		`CHK("sil", 1'b1, sil)
		`CHK("horn", 1'b1, ct[0])
		`CHK("irqm", 1'b0, irq)
		wr(annun_pkg::REG_IRQ_EN, 32'h1); clk(2);
		`CHK("irq", 1'b1, irq)
		wr(annun_pkg::REG_IRQ_CLR, 32'hf); clk(2);
		`CHK("irqc", 1'b0, irq)
		pr(6'h01, 8'h02);
		`CHK("ack", 1'b1, ack)
		`CHK("hush", 1'b0, ct[0])
		rdr(annun_pkg::REG_STATUS);
		`CHK("fclr", 1'b0, rd[5])
		pr(6'h20, 8'h02);
		`CHK("rst", 1'b1, rst)
		alarm <= 16'h0000; pr(6'h01, 8'h02);
		`CHK("quiet", 21'h100000, {on, sil, ack, rst, flt, leds})
		$display("test alarm done");
	endtask
	task automatic t_lamp;
		req <= 6'h01; hold <= 8'd70; @(posedge aclk); req <= 6'h00; clk(30);
		`CHK("lamp", 16'h8888, dig)
		clk(40);
		`CHK("fault", 2'b10, {flt, ct[1]})
		clk(40);
		jmp <= 4'hf; clk(4);
		`CHK("jump", 4'hd, ct)
		jmp <= 4'h0;
		$display("test lamp done");
	endtask
	task automatic t_read;
		alarm <= 16'h0040; clk(6); alarm <= 16'h0000;
		pr(6'h01, 8'h01);
		pr(6'h02, 8'h01);
		`CHK("new", 16'h1107, dig)
		pr(6'h02, 8'h01);
		`CHK("old", 16'h2104, dig)
		pr(6'h02, 8'h01);
		`CHK("blank", 1'b1, blank)
		pr(6'h02, 8'h01);
		`CHK("again", 16'h1107, dig)
		rdr(8'h40);
		`CHK("unmap", 34'h2_0000_0000, {rp, rd})
		wr(8'h40, 32'h0);
		`CHK("werr", 2'h2, bp)
		$display("test readout done");
	endtask
	task automatic t_prog;
		blk <= 1; pr(6'h02, 8'd30); rdr(annun_pkg::REG_STATUS);
		`CHK("nprog", 1'b0, rd[6])
		rdr(annun_pkg::REG_IRQ_STAT);
		`CHK("refuse", 1'b1, rd[3])
		blk <= 0; pr(6'h02, 8'd30); rdr(annun_pkg::REG_STATUS);
		`CHK("prog", 1'b1, rd[6])
		`CHK("pled", 1'b1, pl)
		rdr(annun_pkg::REG_SLOG_DATA);
		`CHK("slog", 4'h2, rd[9:6])
		pr(6'h02, 8'h01); pr(6'h02, 8'h01);
		`CHK("erased", 1'b1, blank)
		wr(annun_pkg::REG_SEQPROG, 32'h0000_00aa);
		aresetn <= 0;
		clk(2);
		aresetn <= 1;
		clk(3);
		rdr(annun_pkg::REG_SEQPROG);
		`CHK("keep", 32'h0000_00aa, rd)
		$display("test programming done");
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin mismatches++; print_verdict(); end
	end
	initial begin
		clk(2); aresetn <= 1; clk(3);
		wr(annun_pkg::REG_SEQPROG, 32'h0); wr(annun_pkg::REG_IRQ_EN, 32'h0);
		t_alarm(); t_lamp(); t_read(); t_prog();
		print_verdict();
	end
endmodule
`default_nettype wire
